//--- include/gcpc_pkg.sv
// Function
// RL1 - software sets single-pulse enable, then go/done
// RL2 - armed acquisition counts from next gate rise
// RL3 - hardware clears go/done on trailing edge
// RL4 - later gate events ignored until go set
// RL5 - clearing single-pulse enable clears go/done
// RL6 - toggle plus single-pulse measures full cycle
// RL7 - gate level readable even when gating disabled
// RL8 - gate falling edge sets gate-event flag, interrupt
// RL9 - gate-event flag works without gate count enable
// RL10 - counter wraps at maximum, sets overflow flag
// RL11 - software enables overflow interrupt chain
// RL12 - overflow flag held until software clears
// RL13 - software clears count and flag first
// RL14 - sleep counting only in asynchronous external mode
// RL15 - enabled overflow in sleep wakes device
// RL16 - external count needs falling edge before rise
// RL17 - capture copies count into capture/compare pair
// RL18 - compare equality raises event, maybe special trigger
// RL19 - special trigger clears count without overflow
// RL20 - special trigger makes compare pair the period
// RL21 - software uses synchronous clock with trigger
// RL22 - count write beats coincident special trigger
// RL23 - active gate counts, inactive gate holds
// RL24 - toggle flip-flop, cleared while toggle disabled
// RL25 - two-bit select picks one of four gates
// RL26 - gate status uses polarity and toggle result
package gcpc_pkg;

    localparam int          CNT_W     = 16;
    localparam int          BYTE_W    = 8;
    localparam int          LOW_LSB   = 0;
    localparam int          HIGH_LSB  = 8;
    localparam logic [15:0] CNT_RST   = 16'h0000;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;

    // gate source select codes
    localparam logic [1:0]  GSRC_PIN  = 2'h0;
    localparam logic [1:0]  GSRC_TMR0 = 2'h1;
    localparam logic [1:0]  GSRC_TMR2 = 2'h2;
    localparam logic [1:0]  GSRC_WDT  = 2'h3;

    // count clock select codes; bit 1 set means external count input
    localparam logic [1:0]  CS_INSTR  = 2'h0;
    localparam logic [1:0]  CS_SYS    = 2'h1;
    localparam int          CS_EXT_BIT = 1;

    // capture/compare modes
    localparam logic [1:0]  CCM_OFF     = 2'h0;
    localparam logic [1:0]  CCM_CAPTURE = 2'h1;
    localparam logic [1:0]  CCM_COMPARE = 2'h2;
    localparam logic [1:0]  CCM_SPECIAL = 2'h3;

    // instruction clock ratio
    localparam int          INSTR_DIV  = 4;

    typedef struct packed {
        logic       count_enable;
        logic       polarity;
        logic       toggle_enable;
        logic       single_pulse_enable;
        logic [1:0] source_select;
    } gcpc_gate_cfg_type;

    typedef struct packed {
        logic       counter_on;
        logic [1:0] clock_select;
        logic       sync_bypass;
    } gcpc_clk_cfg_type;

    typedef struct packed {
        logic       wr_low;
        logic       wr_high;
        logic [7:0] data;
    } gcpc_byte_wr_type;

    typedef struct packed {
        logic tmr0_overflow;
        logic tmr2_match;
        logic wdt_overflow;
    } gcpc_int_src_type;

endpackage

//--- src/gcpc_sync.sv
`timescale 1ns/1ps
module gcpc_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_b,
    // asynchronous level in, filtered level out
    input  wire logic async_in,
    output logic      sync_out
);

    logic stage1;
    logic stage2;
    logic stage3;

    // output follows once the second and third stages agree
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1   <= RST_VAL;
            stage2   <= RST_VAL;
            stage3   <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                sync_out <= stage3;
            end
        end
    end

endmodule

//--- src/gcpc_timer.sv
`timescale 1ns/1ps
module gcpc_timer #(
    parameter int INSTR_DIV = gcpc_pkg::INSTR_DIV
) (
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rst_b,
    // configuration
    input  wire gcpc_pkg::gcpc_clk_cfg_type  clk_cfg,
    input  wire gcpc_pkg::gcpc_gate_cfg_type gate_cfg,
    input  wire logic [1:0]                 capcomp_mode,
    input  wire logic                       overflow_irq_enable,
    input  wire logic                       gate_event_irq_enable,
    input  wire logic                       sleep_mode,
    // software strobes
    input  wire logic                       gate_go_set,
    input  wire logic                       overflow_flag_clear,
    input  wire logic                       gate_event_flag_clear,
    input  wire gcpc_pkg::gcpc_byte_wr_type  count_wr,
    input  wire gcpc_pkg::gcpc_byte_wr_type  capcomp_wr,
    // pins
    input  wire logic                       gate_pin,
    input  wire logic                       ext_count_input,
    // internal gate sources and capture event
    input  wire gcpc_pkg::gcpc_int_src_type  int_src,
    input  wire logic                       capture_event,
    // status
    output logic [15:0]                     count_value,
    output logic [15:0]                     capcomp_value,
    output logic                            gate_acquire_go_done,
    output logic                            gate_level_value,
    output logic                            gate_event_flag,
    output logic                            gate_event_irq,
    output logic                            overflow_flag,
    output logic                            overflow_irq,
    output logic                            wake_request,
    output logic                            compare_event,
    output logic                            special_trigger
);

    localparam int DIV_W = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INSTR_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_ZERO = '0;

    typedef enum logic [1:0] {
        SP_IDLE,
        SP_ARMED,
        SP_COUNT
    } gcpc_sp_state_type;

    // synchronised pins
    logic gate_pin_q;
    logic ext_in_q;

    gcpc_sync u_gate_sync (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .async_in (gate_pin),
        .sync_out (gate_pin_q)
    );

    gcpc_sync u_ext_sync (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .async_in (ext_count_input),
        .sync_out (ext_in_q)
    );

    // count clock edge
    logic [DIV_W-1:0]  div_cnt;
    logic              ext_prev;
    logic              ext_armed;
    wire logic         instr_tick;
    wire logic         ext_rise;
    wire logic         ext_fall;
    wire logic         ext_sel;
    wire logic         tick;

    assign instr_tick = (div_cnt == DIV_LAST);
    assign ext_rise   = ext_in_q & ~ext_prev;
    assign ext_fall   = ~ext_in_q & ext_prev;
    assign ext_sel    = clk_cfg.clock_select[gcpc_pkg::CS_EXT_BIT];
    // first rise after enable counts only once a fall has been seen
    assign tick = ext_sel ? (ext_rise & ext_armed) :                        // RL16
                  (clk_cfg.clock_select == gcpc_pkg::CS_SYS) ? 1'b1 :
                  instr_tick;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt <= DIV_ZERO;
        end else if (instr_tick) begin
            div_cnt <= DIV_ZERO;
        end else begin
            div_cnt <= div_cnt + DIV_W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_prev  <= 1'b0;
            ext_armed <= 1'b0;
        end else begin
            ext_prev <= ext_in_q;
            if (!clk_cfg.counter_on || !ext_sel) begin
                ext_armed <= 1'b0;
            end else if (ext_fall) begin
                ext_armed <= 1'b1; // RL16
            end
        end
    end

    // gate path
    logic              gate_act_prev;
    logic              toggle_ff;
    wire logic         gate_src;
    wire logic         gate_act;
    wire logic         gate_act_rise;
    wire logic         gated;
    wire logic         gated_rise;
    wire logic         gated_fall;

    assign gate_src =
        (gate_cfg.source_select == gcpc_pkg::GSRC_PIN)  ? gate_pin_q :      // RL25
        (gate_cfg.source_select == gcpc_pkg::GSRC_TMR0) ? int_src.tmr0_overflow :
        (gate_cfg.source_select == gcpc_pkg::GSRC_TMR2) ? int_src.tmr2_match :
        int_src.wdt_overflow;
    // polarity high means a high source is active
    assign gate_act      = gate_cfg.polarity ? gate_src : ~gate_src;         // RL23
    assign gate_act_rise = gate_act & ~gate_act_prev;
    assign gated         = gate_cfg.toggle_enable ? toggle_ff : gate_act;    // RL26
    assign gated_rise    = gated & ~gate_level_value;
    assign gated_fall    = ~gated & gate_level_value;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            gate_act_prev <= 1'b0;
            toggle_ff     <= 1'b0;
        end else begin
            gate_act_prev <= gate_act;
            if (!gate_cfg.toggle_enable) begin
                toggle_ff <= 1'b0; // RL24
            end else if (gate_act_rise) begin
                toggle_ff <= ~toggle_ff; // RL24
            end
        end
    end

    // level readback runs regardless of gate count enable
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            gate_level_value <= 1'b0;
        end else begin
            gate_level_value <= gated; // RL7
        end
    end

    // single-pulse acquisition
    gcpc_sp_state_type sp_state;
    gcpc_sp_state_type next_sp_state;
    logic              next_go_done;

    always_comb begin
        next_sp_state = sp_state;
        next_go_done  = gate_acquire_go_done;
        if (!gate_cfg.single_pulse_enable) begin
            next_sp_state = SP_IDLE;
            next_go_done  = 1'b0; // RL5
        end else begin
            case (sp_state)
                SP_IDLE: begin
                    if (gate_go_set) begin
                        next_sp_state = SP_ARMED; // RL1
                        next_go_done  = 1'b1;
                    end
                end
                SP_ARMED: begin
                    if (gated_rise) begin
                        next_sp_state = SP_COUNT; // RL2
                    end
                end
                SP_COUNT: begin
                    if (gated_fall) begin
                        next_sp_state = SP_IDLE; // RL3
                        next_go_done  = 1'b0; // RL3
                    end
                end
                default: begin
                    next_sp_state = SP_IDLE;
                    next_go_done  = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sp_state             <= SP_IDLE;
            gate_acquire_go_done <= 1'b0;
        end else begin
            sp_state             <= next_sp_state;
            gate_acquire_go_done <= next_go_done;
        end
    end

    // with toggle on, the pulse seen here spans a whole source cycle
    wire logic sp_open;
    wire logic gate_ok;

    assign sp_open = (sp_state == SP_COUNT) & gate_level_value;              // RL4 RL6
    assign gate_ok = !gate_cfg.count_enable ? 1'b1 :
                     gate_cfg.single_pulse_enable ? sp_open :                // RL4
                     gate_level_value;                                       // RL23

    // counter
    logic [15:0]       count;
    logic [15:0]       next_count;
    wire logic         sleep_ok;
    wire logic         inc_en;
    wire logic         wrap;
    wire logic         any_wr;

    // asynchronous external counting is the only mode alive in sleep
    assign sleep_ok = ext_sel & clk_cfg.sync_bypass;                         // RL14
    assign inc_en   = clk_cfg.counter_on & tick & gate_ok &
                      (~sleep_mode | sleep_ok);                              // RL14
    assign wrap     = inc_en & (count == gcpc_pkg::CNT_MAX);                 // RL10
    assign any_wr   = count_wr.wr_low | count_wr.wr_high;

    always_comb begin
        next_count = count;
        if (any_wr) begin
            if (count_wr.wr_low) begin
                next_count[gcpc_pkg::LOW_LSB +: gcpc_pkg::BYTE_W] = count_wr.data;
            end
            if (count_wr.wr_high) begin
                next_count[gcpc_pkg::HIGH_LSB +: gcpc_pkg::BYTE_W] = count_wr.data;
            end
        end else if (special_trigger) begin
            next_count = gcpc_pkg::CNT_RST; // RL19 RL20
        end else if (inc_en) begin
            next_count = count + 16'h0001; // RL10 RL23
        end
    end

    // write beats the trigger clear through the priority above
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= gcpc_pkg::CNT_RST;
        end else begin
            count <= next_count; // RL22
        end
    end

    assign count_value = count;

    // flags
    // a set in the same cycle as its clear wins
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            overflow_flag <= 1'b0;
        end else if (wrap && !any_wr && !special_trigger) begin
            overflow_flag <= 1'b1; // RL10
        end else if (overflow_flag_clear) begin
            overflow_flag <= 1'b0; // RL12
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            gate_event_flag <= 1'b0;
        end else if (gated_fall) begin
            gate_event_flag <= 1'b1; // RL8 RL9
        end else if (gate_event_flag_clear) begin
            gate_event_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            gate_event_irq <= 1'b0;
            overflow_irq   <= 1'b0;
            wake_request   <= 1'b0;
        end else begin
            gate_event_irq <= gate_event_flag & gate_event_irq_enable;       // RL8
            overflow_irq   <= overflow_flag & overflow_irq_enable;           // RL11
            wake_request   <= sleep_mode & overflow_flag &
                              overflow_irq_enable & clk_cfg.counter_on;      // RL15
        end
    end

    // capture and compare
    logic [15:0]       capcomp;
    logic              match_prev;
    wire logic         cmp_mode;
    wire logic         match;
    wire logic         match_rise;
    wire logic         do_capture;

    assign cmp_mode   = (capcomp_mode == gcpc_pkg::CCM_COMPARE) |
                        (capcomp_mode == gcpc_pkg::CCM_SPECIAL);
    assign match      = cmp_mode & (capcomp == count);                       // RL18
    assign match_rise = match & ~match_prev;
    assign do_capture = capture_event & (capcomp_mode == gcpc_pkg::CCM_CAPTURE);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            capcomp <= gcpc_pkg::CNT_RST;
        end else if (capcomp_wr.wr_low || capcomp_wr.wr_high) begin
            if (capcomp_wr.wr_low) begin
                capcomp[gcpc_pkg::LOW_LSB +: gcpc_pkg::BYTE_W] <= capcomp_wr.data;
            end
            if (capcomp_wr.wr_high) begin
                capcomp[gcpc_pkg::HIGH_LSB +: gcpc_pkg::BYTE_W] <= capcomp_wr.data;
            end
        end else if (do_capture) begin
            capcomp <= count; // RL17
        end
    end

    assign capcomp_value = capcomp;

    // one event per arrival at the match value
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            match_prev      <= 1'b0;
            compare_event   <= 1'b0;
            special_trigger <= 1'b0;
        end else begin
            match_prev      <= match;
            compare_event   <= match_rise;                                   // RL18
            special_trigger <= match_rise &
                               (capcomp_mode == gcpc_pkg::CCM_SPECIAL);      // RL19 RL20
        end
    end

endmodule

//--- test/gcpc_timer_props.sv
`timescale 1ns/1ps
module gcpc_timer_props (
    // clock and reset
    input wire logic                        sys_clk,
    input wire logic                        rst_b,
    // watched inputs
    input wire gcpc_pkg::gcpc_gate_cfg_type gate_cfg,
    input wire logic [1:0]                  capcomp_mode,
    input wire logic                        overflow_flag_clear,
    input wire gcpc_pkg::gcpc_byte_wr_type  count_wr,
    input wire gcpc_pkg::gcpc_int_src_type  int_src,
    input wire logic                        capture_event,
    // watched outputs
    input wire logic [15:0]                 count_value,
    input wire logic [15:0]                 capcomp_value,
    input wire logic                        gate_acquire_go_done,
    input wire logic                        gate_level_value,
    input wire logic                        gate_event_flag,
    input wire logic                        overflow_flag,
    input wire logic                        special_trigger
);
    default clocking dflt @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    wire logic cwr = count_wr.wr_low | count_wr.wr_high;
    wire logic t0_plain = gate_cfg.source_select == gcpc_pkg::GSRC_TMR0 && !gate_cfg.toggle_enable;

    AST_EVT_FLAG: assert property ($fell(gate_level_value) |-> ##[0:1] gate_event_flag)
        else $error("no gate flag");
    AST_GO_CLR: assert property (gate_acquire_go_done && $fell(gate_level_value)
        |-> ##[0:1] !gate_acquire_go_done)
        else $error("go/done kept");
    AST_SPM_CLR: assert property (!gate_cfg.single_pulse_enable |=> !gate_acquire_go_done)
        else $error("go/done kept, spm off");
    AST_OVF_SET: assert property ($past(count_value) == 16'hFFFF && count_value == 16'h0000
        && !$past(special_trigger) && !$past(cwr) |-> overflow_flag)
        else $error("no overflow flag");
    AST_OVF_HOLD: assert property (overflow_flag && !overflow_flag_clear |=> overflow_flag)
        else $error("overflow flag lost");
    AST_TRIG_CLR: assert property (special_trigger && !cwr |=> count_value == 16'h0000)
        else $error("count not cleared");
    AST_WR_WIN: assert property (special_trigger && count_wr.wr_low && count_wr.wr_high
        |=> count_value == {2{$past(count_wr.data)}})
        else $error("count write lost");
    AST_MATCH: assert property (capcomp_mode == gcpc_pkg::CCM_SPECIAL
        && count_value == capcomp_value && $changed(count_value) |=> special_trigger)
        else $error("no trigger");
    AST_CAPT: assert property (capcomp_mode == gcpc_pkg::CCM_CAPTURE && capture_event
        |=> capcomp_value == $past(count_value))
        else $error("no capture");
    AST_HOLD: assert property (gate_cfg.count_enable && !gate_level_value
        && !special_trigger && !cwr |=> $stable(count_value))
        else $error("count moved");
    AST_LEVEL: assert property (t0_plain ##1 t0_plain && $stable(gate_cfg.polarity)
        |-> gate_level_value == ($past(int_src.tmr0_overflow) ~^ gate_cfg.polarity))
        else $error("bad gate level");

    cover property (special_trigger);
    cover property ($fell(gate_acquire_go_done));
    cover property ($rose(overflow_flag));
endmodule

//--- test/gcpc_src_model.sv
`timescale 1ns/1ps
module gcpc_src_model (
    // clock
    input  wire logic                  sys_clk,
    // pulse request from the bench
    input  wire logic                  fire,
    input  wire logic [1:0]            fire_sel,
    input  wire logic [7:0]            fire_len,
    // gate sources towards the timer
    output logic                       gate_pin,
    output gcpc_pkg::gcpc_int_src_type int_src
);
    logic [7:0] left = 8'h00;
    logic [1:0] sel = 2'h0;
    logic       on = 1'b0;
    always @(posedge sys_clk) begin
        if (fire) begin
            left <= fire_len;
            sel <= fire_sel;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
    // lines move off the sampling edge, like a real source
    always @(negedge sys_clk) begin
        on <= left != 8'h00;
    end
    assign gate_pin = on && sel == gcpc_pkg::GSRC_PIN;
    assign int_src = '{on && sel == gcpc_pkg::GSRC_TMR0,
                       on && sel == gcpc_pkg::GSRC_TMR2,
                       on && sel == gcpc_pkg::GSRC_WDT};
endmodule

//--- test/gcpc_timer_tb.sv
`timescale 1ns/1ps
bind gcpc_timer gcpc_timer_props chk_u (.sys_clk, .rst_b, .gate_cfg, .capcomp_mode,
    .overflow_flag_clear, .count_wr, .int_src, .capture_event, .count_value, .capcomp_value,
    .gate_acquire_go_done, .gate_level_value, .gate_event_flag, .overflow_flag,
    .special_trigger);
module gcpc_timer_tb;
    logic                        sys_clk = 1'b0;
    logic                        rst_b = 1'b0;
    gcpc_pkg::gcpc_clk_cfg_type  clk_cfg = '0;
    gcpc_pkg::gcpc_gate_cfg_type gate_cfg = '0;
    logic [1:0]                  capcomp_mode = 2'h0, fire_sel = 2'h0;
    logic                        ovf_ie = 1'b0, gev_ie = 1'b0, sleep_mode = 1'b0, go_set = 1'b0;
    logic                        ovf_clr = 1'b0, gev_clr = 1'b0, ext_in = 1'b0, fire = 1'b0;
    logic                        capture_event = 1'b0, gate_pin;
    gcpc_pkg::gcpc_byte_wr_type  count_wr = '0, capcomp_wr = '0;
    logic [7:0]                  fire_len = 8'h00;
    gcpc_pkg::gcpc_int_src_type  int_src;
    logic [15:0]                 count, capcomp, per, mx, rnd = 16'h0040;
    logic                        go_done, level, gflag, girq, oflag, oirq, wake, trig, cev;
    int                          ntrig, mismatches = 0, num_checks = 0;

    always #5 sys_clk = ~sys_clk;

    gcpc_src_model src_u (.sys_clk, .fire, .fire_sel, .fire_len, .gate_pin, .int_src);

    gcpc_timer dut_u (.sys_clk, .rst_b, .clk_cfg, .gate_cfg, .capcomp_mode,
        .overflow_irq_enable(ovf_ie), .gate_event_irq_enable(gev_ie), .sleep_mode,
        .gate_go_set(go_set), .overflow_flag_clear(ovf_clr), .gate_event_flag_clear(gev_clr),
        .count_wr, .capcomp_wr, .gate_pin, .ext_count_input(ext_in), .int_src, .capture_event,
        .count_value(count), .capcomp_value(capcomp), .gate_acquire_go_done(go_done),
        .gate_level_value(level), .gate_event_flag(gflag), .gate_event_irq(girq),
        .overflow_flag(oflag), .overflow_irq(oirq), .wake_request(wake),
        .compare_event(cev), .special_trigger(trig));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic exp_level(input logic on, input logic pol);
        return on ~^ pol;
    endfunction
    function automatic logic [15:0] after(input logic [15:0] s, input int n);
        return s + 16'(n);
    endfunction

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic end_sim();
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        chk(n, {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic wait_for(input logic on_trig, input logic v);
        for (int i = 0; i < 400 && (on_trig ? trig : go_done) !== v; i++) begin
            tick(1);
        end
        if ((on_trig ? trig : go_done) !== v) begin
            mismatches++;
            end_sim();
        end
    endtask
    task automatic wr16(input logic cc, input logic [15:0] v);
        for (int b = 0; b < 2; b++) begin
            count_wr = '{!cc && b == 0, !cc && b == 1, v[8*b +: 8]};
            capcomp_wr = '{cc && b == 0, cc && b == 1, v[8*b +: 8]};
            tick(1);
        end
        count_wr = '0;
        capcomp_wr = '0;
    endtask
    task automatic fire_src(input logic [1:0] s, input logic [7:0] n);
        fire_sel = s;
        fire_len = n;
        fire = 1'b1;
        tick(1);
        fire = 1'b0;
    endtask
    task automatic arm();
        go_set = 1'b1;
        tick(1);
        go_set = 1'b0;
    endtask

    initial begin
        tick(6);
        rst_b = 1'b1;
        wr16(1'b0, 16'hFFFD);
        ovf_ie = 1'b1;
        clk_cfg = '{1'b1, gcpc_pkg::CS_SYS, 1'b0};
        tick(5);
        chk("count", after(16'hFFFD, 5), count);
        chk1("ovf flag", 1'b1, oflag);
        chk1("ovf irq", 1'b1, oirq);
        sleep_mode = 1'b1;
        tick(3);
        chk("sleep count", after(16'hFFFD, 5), count);
        chk1("wake", 1'b1, wake);
        rnd = lfsr(rnd);
        tick(int'(rnd[3:0]) + 1);
        chk1("ovf held", 1'b1, oflag);
        ovf_clr = 1'b1;
        tick(1);
        ovf_clr = 1'b0;
        chk1("ovf cleared", 1'b0, oflag);
        wr16(1'b0, 16'h0000);
        clk_cfg = '{1'b1, 2'h2, 1'b1};
        for (int k = 0; k < 5; k++) begin
            tick(8);
            if (k == 3) begin
                chk("ext count", 16'h0001, count);
                clk_cfg.sync_bypass = 1'b0;
            end
            ext_in = ~ext_in;
        end
        tick(8);
        chk("sleep sync count", 16'h0001, count);
        sleep_mode = 1'b0;
        clk_cfg = '0;
        rnd = lfsr(rnd);
        per = {12'h000, rnd[3:0]} + 16'h0003;
        wr16(1'b1, per);
        wr16(1'b0, 16'h0000);
        capcomp_mode = gcpc_pkg::CCM_SPECIAL;
        clk_cfg = '{1'b1, gcpc_pkg::CS_INSTR, 1'b0};
        mx = 16'h0000;
        ntrig = 0;
        repeat (12 * (int'(per) + 3)) begin
            tick(1);
            if (count > mx) mx = count;
            ntrig += int'(trig);
            chk1("compare event", trig, cev);
        end
        chk1("period", 1'b1, mx >= per && mx <= per + 16'h0001);
        chk1("trigger seen", 1'b1, ntrig > 2);
        chk1("no ovf", 1'b0, oflag);
        wait_for(1'b1, 1'b1);
        rnd = lfsr(rnd);
        count_wr = '{1'b1, 1'b1, rnd[7:0]};
        tick(1);
        count_wr = '0;
        chk("write wins", {rnd[7:0], rnd[7:0]}, count);
        capcomp_mode = gcpc_pkg::CCM_CAPTURE;
        clk_cfg.clock_select = gcpc_pkg::CS_SYS;
        tick(int'(rnd[11:8]) + 1);
        per = count;
        capture_event = 1'b1;
        tick(1);
        capture_event = 1'b0;
        chk("capture", per, capcomp);
        capcomp_mode = gcpc_pkg::CCM_OFF;
        gev_ie = 1'b1;
        for (int s = 0; s < 4; s++) begin
            for (int p = 0; p < 2; p++) begin
                gate_cfg = '{1'b0, p[0], 1'b0, 1'b0, s[1:0]};
                tick(8);
                gev_clr = 1'b1;
                tick(1);
                gev_clr = 1'b0;
                chk1("gate idle", exp_level(1'b0, p[0]), level);
                chk1("flag clear", 1'b0, gflag);
                fire_src(s[1:0], 8'h0C);
                tick(7);
                chk1("gate active", exp_level(1'b1, p[0]), level);
                tick(12);
                chk1("gate flag", 1'b1, gflag);
                chk1("gate irq", 1'b1, girq);
            end
        end
        wr16(1'b0, 16'h0000);
        gate_cfg = '{1'b1, 1'b1, 1'b0, 1'b1, gcpc_pkg::GSRC_TMR0};
        arm();
        chk1("armed", 1'b1, go_done);
        rnd = lfsr(rnd);
        per = {12'h000, rnd[3:0]} + 16'h0003;
        fire_src(gcpc_pkg::GSRC_TMR0, per[7:0]);
        wait_for(1'b0, 1'b0);
        chk1("pulse count", 1'b1, count + 16'h0001 >= per && count <= per);
        per = count;
        fire_src(gcpc_pkg::GSRC_TMR0, 8'h06);
        tick(12);
        chk("no rearm", per, count);
        arm();
        gate_cfg.single_pulse_enable = 1'b0;
        tick(1);
        chk1("spm off", 1'b0, go_done);
        wr16(1'b0, 16'h0000);
        gate_cfg = '{1'b1, 1'b1, 1'b1, 1'b1, gcpc_pkg::GSRC_TMR0};
        arm();
        fire_src(gcpc_pkg::GSRC_TMR0, 8'h04);
        tick(10);
        fire_src(gcpc_pkg::GSRC_TMR0, 8'h04);
        wait_for(1'b0, 1'b0);
        chk1("cycle count", 1'b1, count >= 16'h000A && count <= 16'h000C);
        end_sim();
    end
endmodule
